//--- dcd_core.sv
// dsp core datapath, stack, user pins, interrupt sequencer and ahb-lite registers
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps

// What this block does
// - most ops one cycle; jumps, calls, long two
// - signed 16x16 multiply or mac per cycle
// - keep bits 30 to 7 of 32-bit product
// - operands fractional two's complement values
// - 8000h times 8000h yields 800000h
// - product shifter: none or right three
// - one operand loads x and y; x readable
// - alu: accumulator plus product or bus<<8
// - six-level stack for addresses or data
// - call pushes pc+2; return pops into pc
// - user inputs zero, one in status bits
// - all three user inputs feed timer clocks
// - user outputs drive inverted status five, six
// - external interrupts select rising or falling edge
// - five internal plus three external sources
// - three fixed levels, zero is highest
// - per-source enable and level assignment
// - entry at boundary, two cycles, pushes pc
// - vectors at top three program words
// - enable instruction sets; entry clears global enable
// - seven banked slots, general count by bank
// - accumulator write upper sixteen, read upper sixteen
// - product register read-only, latest product
module dcd_core
   import dcd_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic [2:0]  i_user_in,
   output logic      [2:0]  o_timer_clk_src,
   input  wire logic [1:0]  i_timer_out,
   output logic      [1:0]  o_pin_out,
   input  wire logic [2:0]  i_ext_irq,
   input  wire logic [4:0]  i_periph_irq,
   output logic      [15:0] o_vec_addr,
   output logic             o_vec_rd,
   input  wire logic [15:0] i_vec_data,
   output logic      [2:0]  o_ext_addr,
   output logic             o_ext_wr,
   output logic             o_ext_rd,
   output logic      [15:0] o_ext_wdata,
   input  wire logic [15:0] i_ext_rdata,
   output logic             o_busy
);

   typedef struct packed {
      dcd_state_t       state;
      logic [15:0]      x;
      logic [15:0]      y;
      logic [23:0]      p;
      logic [23:0]      acc;
      logic [15:0]      pc;
      logic [5:0][15:0] stk;
      logic [2:0]       sp;
      logic [15:0]      sr;
      logic             shift3;
      logic             uo_en;
      logic [2:0]       pol;
      logic [3:0]       bank;
      logic             gie;
      logic [7:0]       irq_en;
      logic [15:0]      irq_pri;
      logic [7:0]       pend;
      logic [4:0]       op;
      logic [15:0]      opnd;
      logic [2:0]       ui_s1;
      logic [2:0]       ui_s2;
      logic [2:0]       ei_s1;
      logic [2:0]       ei_s2;
      logic [2:0]       ei_d;
      logic [6:0][15:0] slot;
      logic             a_vld;
      logic             a_wr;
      logic [5:0]       a_idx;
      logic             rd_wait;
      logic [31:0]      hrdata;
      logic [1:0]       pin;
      logic [15:0]      vec_addr;
      logic             vec_rd;
      logic [2:0]       ext_addr;
      logic             ext_wr;
      logic             ext_rd;
      logic [15:0]      ext_wdata;
   } dcd_regs_t;

   dcd_regs_t          r;
   dcd_regs_t          next_r;
   logic signed [31:0] full_prod;
   logic [23:0]        prod;
   logic [23:0]        shp;
   logic               wr_act;
   logic               wr_cmd;
   logic [4:0]         cmd_op;
   logic [15:0]        imm;
   logic [7:0]         act;
   logic [7:0]         ev;
   logic [1:0]         best;
   logic [7:0]         take_src;
   logic               take;
   logic [31:0]        rd_val;
   logic [2:0]         rd_slot;
   logic [2:0]         wr_slot;
   logic [2:0]         ad_slot;
   logic [1:0]         src_lvl [8];

   function automatic logic slot_general(input logic [2:0] s, input logic [3:0] b);
      return (b <= BANK_LAST) && ({1'b0, s} < 4'(b + SLOT_BASE));
   endfunction : slot_general

   function automatic logic is_slot(input logic [5:0] idx);
      return (idx >= IDX_SLOT0) && (idx < IDX_SLOTN);
   endfunction : is_slot

   ////////////////////////////////////////////////////////////////////////////
   // multiplier and shifter
   // fractional alignment drops the duplicated sign bit, so -1 x -1 wraps to -1
   assign full_prod = $signed(r.x) * $signed(r.y);
   assign prod      = full_prod[30:7];
   assign shp       = r.shift3 ? {{3{r.p[23]}}, r.p[23:3]} : r.p;

   assign wr_act  = r.a_vld && r.a_wr;
   assign wr_cmd  = wr_act && (r.a_idx == IDX_CMD) && (r.state == ST_RUN);
   assign cmd_op  = i_hwdata[CMD_OP_LSB +: 5];
   assign imm     = i_hwdata[CMD_IMM_LSB +: 16];
   assign rd_slot = 3'(r.a_idx - IDX_SLOT0);
   assign wr_slot = rd_slot;
   assign ad_slot = 3'(i_haddr[7:2] - IDX_SLOT0);

   ////////////////////////////////////////////////////////////////////////////
   // interrupt arbitration
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         ev[i] = r.pol[i] ? (r.ei_s2[i] && !r.ei_d[i])
                          : (!r.ei_s2[i] && r.ei_d[i]);
      end
      ev[7:3] = i_periph_irq;
      act     = r.pend & r.irq_en;
      best    = 2'h3;
      for (int i = 0; i < 8; i++) begin
         src_lvl[i] = (r.irq_pri[2*i +: 2] == 2'h3) ? LVL_LOW : r.irq_pri[2*i +: 2];
         if (act[i] && (src_lvl[i] < best)) begin
            best = src_lvl[i];
         end
      end
      take_src = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         if (act[i] && (src_lvl[i] == best)) begin
            take_src = 8'(1 << i);
         end
      end
   end

   // boundary only: a command starting this cycle goes first
   assign take = (r.state == ST_RUN) && !wr_cmd && r.gie && (|act);

   ////////////////////////////////////////////////////////////////////////////
   // register read mux
   always_comb begin
      unique case (r.a_idx)
         IDX_CMD:    rd_val = {31'h0, r.state != ST_RUN};
         IDX_X:      rd_val = {16'h0, r.x};
         IDX_Y:      rd_val = {16'h0, r.y};
         IDX_P:      rd_val = {8'h0, r.p};
         IDX_ACC:    rd_val = {16'h0, r.acc[23:8]};
         IDX_ACCF:   rd_val = {8'h0, r.acc};
         IDX_PC:     rd_val = {16'h0, r.pc};
         IDX_STATUS: rd_val = {16'h0, r.sr[15:12], r.ui_s2[1:0], r.sr[9:0]};
         IDX_CTRL:   rd_val = {19'h0, r.gie, r.bank, 3'h0, r.pol, r.uo_en, r.shift3};
         IDX_IRQEN:  rd_val = {24'h0, r.irq_en};
         IDX_IRQPRI: rd_val = {16'h0, r.irq_pri};
         IDX_IRQPND: rd_val = {24'h0, r.pend};
         IDX_STACK:  rd_val = {13'h0, r.sp,
                               (r.sp == 3'h0) ? 16'h0 : r.stk[3'(r.sp - 3'h1)]};
         default: begin
            if (is_slot(r.a_idx)) begin
               rd_val = {16'h0, slot_general(rd_slot, r.bank) ? r.slot[rd_slot]
                                                             : i_ext_rdata};
            end else begin
               rd_val = 32'h0;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_r        = r;
      next_r.ui_s1  = i_user_in;
      next_r.ui_s2  = r.ui_s1;
      next_r.ei_s1  = i_ext_irq;
      next_r.ei_s2  = r.ei_s1;
      next_r.ei_d   = r.ei_s2;
      next_r.pin    = r.uo_en ? ~{r.sr[SR_UO1], r.sr[SR_UO0]} : i_timer_out;
      next_r.ext_wr = 1'b0;
      next_r.ext_rd = 1'b0;
      next_r.vec_rd = 1'b0;
      next_r.pend   = r.pend;

      // reads take one wait cycle so a write just before is seen
      if (r.rd_wait) begin
         next_r.rd_wait = 1'b0;
         next_r.hrdata  = rd_val;
      end
      if (i_hsel && i_htrans[1] && i_hready) begin
         next_r.a_vld   = 1'b1;
         next_r.a_wr    = i_hwrite;
         next_r.a_idx   = i_haddr[7:2];
         next_r.rd_wait = !i_hwrite;
         if (!i_hwrite && is_slot(i_haddr[7:2]) && !slot_general(ad_slot, r.bank)) begin
            next_r.ext_rd   = 1'b1;
            next_r.ext_addr = ad_slot;
         end
      end else if (i_hready) begin
         next_r.a_vld = 1'b0;
      end

      if (wr_act) begin
         unique case (r.a_idx)
            IDX_X:      next_r.x = i_hwdata[15:0];
            IDX_Y:      next_r.y = i_hwdata[15:0];
            IDX_ACC:    next_r.acc = {i_hwdata[15:0], 8'h00};
            IDX_STATUS: next_r.sr = i_hwdata[15:0];
            IDX_CTRL: begin
               next_r.shift3 = i_hwdata[CTRL_SHIFT];
               next_r.uo_en  = i_hwdata[CTRL_UOEN];
               next_r.pol    = i_hwdata[CTRL_POL +: 3];
               next_r.bank   = i_hwdata[CTRL_BANK +: 4];
            end
            IDX_IRQEN:  next_r.irq_en = i_hwdata[7:0];
            IDX_IRQPRI: next_r.irq_pri = i_hwdata[15:0];
            IDX_IRQPND: next_r.pend = r.pend & ~i_hwdata[7:0];
            default: begin
               if (is_slot(r.a_idx)) begin
                  if (slot_general(wr_slot, r.bank)) begin
                     next_r.slot[wr_slot] = i_hwdata[15:0];
                  end else begin
                     next_r.ext_wr    = 1'b1;
                     next_r.ext_addr  = wr_slot;
                     next_r.ext_wdata = i_hwdata[15:0];
                  end
               end
            end
         endcase
      end

      if (wr_cmd) begin
         next_r.pc = 16'(r.pc + 16'h1);
         unique case (cmd_op)
            OP_LDX: next_r.x = imm;
            OP_LDY: next_r.y = imm;
            OP_SQR: begin
               next_r.x = imm;
               next_r.y = imm;
            end
            OP_MPY: next_r.p = prod;
            OP_MAC: begin
               next_r.acc = 24'(r.acc + shp);
               next_r.p   = prod;
            end
            OP_ADDP: next_r.acc = 24'(r.acc + shp);
            OP_ADDD: next_r.acc = 24'(r.acc + {imm, 8'h00});
            OP_SUBD: next_r.acc = 24'(r.acc - {imm, 8'h00});
            OP_LDA:  next_r.acc = {imm, 8'h00};
            OP_PUSH, OP_CALL: begin
               if (r.sp < STACK_DEPTH) begin
                  next_r.stk[r.sp] = (cmd_op == OP_CALL) ? 16'(r.pc + 16'h2) : imm;
                  next_r.sp        = 3'(r.sp + 3'h1);
               end
            end
            OP_POP, OP_RET: begin
               if (r.sp != 3'h0) begin
                  next_r.sp = 3'(r.sp - 3'h1);
                  if (cmd_op == OP_POP) begin
                     next_r.x = r.stk[3'(r.sp - 3'h1)];
                  end
               end
            end
            OP_SET_GLOBAL_IRQ_ENABLE_INSTR: next_r.gie = 1'b1;
            default: ;
         endcase
         next_r.op   = cmd_op;
         next_r.opnd = (cmd_op == OP_RET && r.sp != 3'h0) ? r.stk[3'(r.sp - 3'h1)] : imm;
         if (cmd_op == OP_LDIL || cmd_op == OP_JMP || cmd_op == OP_CALL || cmd_op == OP_RET) begin
            next_r.pc    = r.pc;
            next_r.state = ST_EXEC2;
         end
      end

      unique case (r.state)
         ST_RUN: begin
            if (take) begin
               if (r.sp < STACK_DEPTH) begin
                  next_r.stk[r.sp] = r.pc;
                  next_r.sp        = 3'(r.sp + 3'h1);
               end
               next_r.gie      = 1'b0;
               next_r.pend     = next_r.pend & ~take_src;
               next_r.vec_addr = 16'(VEC_LEVEL0 - {14'h0, best});
               next_r.vec_rd   = 1'b1;
               next_r.state    = ST_VEC;
            end
         end
         ST_EXEC2: begin
            unique case (r.op)
               OP_LDIL: begin
                  next_r.acc = {r.opnd, 8'h00};
                  next_r.pc  = 16'(r.pc + 16'h2);
               end
               default: next_r.pc = r.opnd;
            endcase
            next_r.state = ST_RUN;
         end
         ST_VEC: begin
            next_r.pc    = i_vec_data;
            next_r.state = ST_RUN;
         end
         default: next_r.state = ST_RUN;
      endcase

      // a new event wins over any clear in the same cycle
      next_r.pend = next_r.pend | ev;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r       <= '0;
         r.state <= ST_RUN;
         r.p     <= P_RESET;
         r.pc    <= PC_RESET;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign o_hrdata        = r.hrdata;
   assign o_hreadyout     = !r.rd_wait;
   assign o_hresp         = 1'b0;
   assign o_timer_clk_src = r.ui_s2;
   assign o_pin_out       = r.pin;
   assign o_vec_addr      = r.vec_addr;
   assign o_vec_rd        = r.vec_rd;
   assign o_ext_addr      = r.ext_addr;
   assign o_ext_wr        = r.ext_wr;
   assign o_ext_rd        = r.ext_rd;
   assign o_ext_wdata     = r.ext_wdata;
   assign o_busy          = r.state != ST_RUN;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence seq_call_issue;
      wr_cmd && (cmd_op == OP_CALL);
   endsequence
   sequence seq_irq_take;
      take;
   endsequence

   a_mult_product: assert property (wr_cmd && cmd_op == OP_MPY |=> r.p == $past(prod))
      else $error("product not latched");
   a_neg_one_wrap: assert property (wr_cmd && cmd_op == OP_MPY && r.x == 16'h8000
      && r.y == 16'h8000 |=> r.p == 24'h800000)
      else $error("minus one squared wrong");
   a_addp_acc: assert property (wr_cmd && cmd_op == OP_ADDP
      |=> r.acc == 24'($past(r.acc) + $past(shp)))
      else $error("acc add of product wrong");
   a_acc_write_low: assert property (wr_act && r.a_idx == IDX_ACC
      |=> r.acc[7:0] == 8'h00 && r.acc[23:8] == $past(i_hwdata[15:0]))
      else $error("acc write placement wrong");
   a_call_two_cycle: assert property (seq_call_issue |=> r.state == ST_EXEC2
      ##1 (r.state == ST_RUN && r.pc == $past(imm, 2)))
      else $error("call timing wrong");
   a_call_push_pc: assert property ((seq_call_issue and (r.sp < STACK_DEPTH))
      |=> r.stk[$past(r.sp)] == 16'($past(r.pc) + 16'h2))
      else $error("call pushed wrong address");
   a_irq_entry_seq: assert property (seq_irq_take |=> (r.state == ST_VEC && !r.gie
      && r.vec_rd) ##1 (r.state == ST_RUN && r.pc == $past(i_vec_data)))
      else $error("interrupt entry wrong");
   a_irq_vector: assert property (seq_irq_take
      |=> r.vec_addr == 16'(VEC_LEVEL0 - {14'h0, $past(best)}))
      else $error("vector address wrong");
   a_pend_hold: assert property (r.pend[0] && !r.gie && !(wr_act && r.a_idx == IDX_IRQPND)
      |=> r.pend[0])
      else $error("pending request lost");
   a_ui_status: assert property (r.rd_wait && r.a_idx == IDX_STATUS
      |=> o_hrdata[11:10] == $past(r.ui_s2[1:0]))
      else $error("user inputs not in status");
   a_user_out: assert property (r.uo_en
      |=> o_pin_out == ~{$past(r.sr[SR_UO1]), $past(r.sr[SR_UO0])})
      else $error("user output not inverted status");

endmodule : dcd_core

//--- dcd_periph_model.sv
// behavioural far side: vector words in program memory and peripheral slot registers
`timescale 1ns/100ps
module dcd_periph_model (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_vec_addr,
   input  wire logic        i_vec_rd,
   input  wire logic [2:0]  i_ext_addr,
   input  wire logic        i_ext_wr,
   input  wire logic        i_ext_rd,
   input  wire logic [15:0] i_ext_wdata,
   output logic      [15:0] o_vec_data,
   output logic      [15:0] o_ext_rdata
);
   logic [15:0] mem [8];
   int          wr_cnt = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // word inverted outside its read cycle, so a late sample cannot pass by luck
   assign o_vec_data  = i_vec_rd ? {i_vec_addr[7:0], 8'h00} : ~{i_vec_addr[7:0], 8'h00};
   assign o_ext_rdata = i_ext_rd ? mem[i_ext_addr] : ~mem[i_ext_addr];
   initial foreach (mem[i]) mem[i] = 16'h0000;
   always @(posedge i_clk) begin
      if (i_ext_wr) begin
         mem[i_ext_addr] <= i_ext_wdata;
         wr_cnt <= wr_cnt + 1;
      end
   end
endmodule : dcd_periph_model

//--- dcd_pkg.sv
// shared constants and types for the dsp core datapath with interrupts
package dcd_pkg;
   // register word indices (byte address = index * 4)
   localparam logic [5:0] IDX_CMD    = 6'h00;
   localparam logic [5:0] IDX_X      = 6'h01;
   localparam logic [5:0] IDX_Y      = 6'h02;
   localparam logic [5:0] IDX_P      = 6'h03;
   localparam logic [5:0] IDX_ACC    = 6'h04;
   localparam logic [5:0] IDX_ACCF   = 6'h05;
   localparam logic [5:0] IDX_PC     = 6'h06;
   localparam logic [5:0] IDX_STATUS = 6'h07;
   localparam logic [5:0] IDX_CTRL   = 6'h08;
   localparam logic [5:0] IDX_IRQEN  = 6'h09;
   localparam logic [5:0] IDX_IRQPRI = 6'h0A;
   localparam logic [5:0] IDX_IRQPND = 6'h0B;
   localparam logic [5:0] IDX_STACK  = 6'h0C;
   localparam logic [5:0] IDX_SLOT0  = 6'h10;
   localparam logic [5:0] IDX_SLOTN  = 6'h17;
   // command word fields
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_IMM_LSB = 16;
   // control register fields
   localparam int CTRL_SHIFT  = 0;
   localparam int CTRL_UOEN   = 1;
   localparam int CTRL_POL    = 2;
   localparam int CTRL_BANK   = 8;
   localparam int CTRL_GIE    = 12;
   // status bits tied to pins
   localparam int SR_UO0 = 5;
   localparam int SR_UO1 = 6;
   localparam int SR_UI0 = 10;
   localparam int SR_UI1 = 11;
   // operation codes
   localparam logic [4:0] OP_NOP  = 5'h00;
   localparam logic [4:0] OP_LDX  = 5'h01;
   localparam logic [4:0] OP_LDY  = 5'h02;
   localparam logic [4:0] OP_SQR  = 5'h03;
   localparam logic [4:0] OP_MPY  = 5'h04;
   localparam logic [4:0] OP_MAC  = 5'h05;
   localparam logic [4:0] OP_ADDP = 5'h06;
   localparam logic [4:0] OP_ADDD = 5'h07;
   localparam logic [4:0] OP_SUBD = 5'h08;
   localparam logic [4:0] OP_LDA  = 5'h09;
   localparam logic [4:0] OP_LDIL = 5'h0A;
   localparam logic [4:0] OP_JMP  = 5'h0B;
   localparam logic [4:0] OP_CALL = 5'h0C;
   localparam logic [4:0] OP_RET  = 5'h0D;
   localparam logic [4:0] OP_PUSH = 5'h0E;
   localparam logic [4:0] OP_POP  = 5'h0F;
   localparam logic [4:0] OP_SET_GLOBAL_IRQ_ENABLE_INSTR = 5'h10;
   // vectors, stack, slots
   localparam logic [15:0] VEC_LEVEL0  = 16'h1FFF;
   localparam logic [2:0]  STACK_DEPTH = 3'h6;
   localparam logic [3:0]  SLOT_BASE   = 4'h3;
   localparam logic [3:0]  BANK_LAST   = 4'h4;
   localparam logic [2:0]  SLOT_COUNT  = 3'h7;
   localparam logic [1:0]  LVL_LOW     = 2'h2;
   localparam logic [23:0] P_RESET     = 24'h000000;
   localparam logic [15:0] PC_RESET    = 16'h0000;

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_EXEC2 = 3'b010,
      ST_VEC   = 3'b100
   } dcd_state_t;
endpackage : dcd_pkg

//--- tb_top.sv
// self-checking bench for the dsp core datapath and interrupt sequencer
`timescale 1ns/100ps
module tb_top
   import dcd_pkg::*;
;
   logic        i_clk = 0, i_nrst = 0, i_hsel = 0, i_hwrite = 0, rd_pend = 0;
   logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata;
   logic [1:0]  i_htrans = 0, i_timer_out = 0, o_pin_out;
   logic [2:0]  i_hsize = 3'h2, i_user_in = 0, i_ext_irq = 0, o_timer_clk_src, o_ext_addr;
   logic [4:0]  i_periph_irq = 0;
   logic [15:0] o_vec_addr, i_vec_data, o_ext_wdata, i_ext_rdata, x, y, t, p16;
   logic        o_hreadyout, o_hresp, o_vec_rd, o_ext_wr, o_ext_rd, o_busy;
   logic [23:0] acc, pr;
   logic [31:0] exp_q[$];
   int          err_count = 0, check_count = 0, cyc = 0, n = 0;
   int          bk[4] = '{0, 0, 4, 5};
   int          sl[4] = '{2, 3, 6, 0};

   dcd_core u_dcd_core (
      .i_clk, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
      .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_user_in,
      .o_timer_clk_src, .i_timer_out, .o_pin_out, .i_ext_irq, .i_periph_irq,
      .o_vec_addr, .o_vec_rd, .i_vec_data, .o_ext_addr, .o_ext_wr, .o_ext_rd,
      .o_ext_wdata, .i_ext_rdata, .o_busy
   );
   dcd_periph_model u_dcd_periph_model (
      .i_clk, .i_vec_addr(o_vec_addr), .i_vec_rd(o_vec_rd), .i_ext_addr(o_ext_addr),
      .i_ext_wr(o_ext_wr), .i_ext_rd(o_ext_rd), .i_ext_wdata(o_ext_wdata),
      .o_vec_data(i_vec_data), .o_ext_rdata(i_ext_rdata)
   );
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #25 i_clk = ~i_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   // hang guard: far above the few hundred bus cycles the run needs
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         test_done();
      end
   end

   // read data is taken at the edge that ends the waited data phase
   always @(posedge i_clk) begin
      if (rd_pend && o_hreadyout === 1'b1) chk(o_hrdata, exp_q.pop_front());
      if (o_hresp !== 1'b0) chk({31'h0, o_hresp}, 32'h0);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
      @(posedge i_clk);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_hwrite <= w;
      i_haddr <= {24'h0, idx, 2'h0};
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      rd_pend <= !w;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      rd_pend <= 1'b0;
   endtask : bus

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [5:0] idx, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, idx, 32'h0);
   endtask : rd

   task automatic cmd(input logic [4:0] op, input logic [15:0] imm);
      bus(1'b1, IDX_CMD, {imm, 11'h0, op});
   endtask : cmd

   function automatic logic [23:0] prod(input logic [15:0] a, input logic [15:0] b);
      logic signed [31:0] m;
      m = $signed(a) * $signed(b);
      return m[30:7];
   endfunction : prod
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hF1E9));
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd(IDX_PC, {16'h0, PC_RESET});
      for (int i = 0; i < 4; i++) begin
         x = i ? 16'($urandom) : 16'h8000;
         y = i ? 16'($urandom) : 16'h8000;
         cmd(OP_LDX, x);
         cmd(OP_LDY, y);
         cmd(OP_MPY, 16'h0);
         rd(IDX_P, {8'h0, prod(x, y)});
      end
      pr = prod(x, y);
      wr(IDX_P, 32'h00FFFFFF);
      rd(IDX_P, {8'h0, pr});
      cmd(OP_SQR, 16'hC123);
      rd(IDX_X, 32'h0000C123);
      rd(IDX_Y, 32'h0000C123);
      cmd(OP_LDA, 16'h1234);
      rd(IDX_ACC, 32'h00001234);
      cmd(OP_ADDD, 16'h0F00);
      cmd(OP_SUBD, 16'h0100);
      cmd(OP_ADDP, 16'h0);
      acc = 24'h123400 + 24'h0F0000 - 24'h010000 + pr;
      rd(IDX_ACCF, {8'h0, acc});
      wr(IDX_CTRL, 32'h1);
      cmd(OP_MAC, 16'h0);
      acc = acc + 24'($signed(pr) >>> 3);
      rd(IDX_ACCF, {8'h0, acc});
      rd(IDX_P, {8'h0, prod(16'hC123, 16'hC123)});
      cmd(OP_JMP, 16'h0100);
      #1 chk({31'h0, o_busy}, 32'h1);
      rd(IDX_PC, 32'h00000100);
      cmd(OP_CALL, 16'h0200);
      rd(IDX_STACK, 32'h00010102);
      rd(IDX_PC, 32'h00000200);
      cmd(OP_RET, 16'h0);
      rd(IDX_PC, 32'h00000102);
      for (int i = 1; i < 8; i++) cmd(OP_PUSH, 16'h00A0 + 16'(i));
      rd(IDX_STACK, 32'h000600A6);
      for (int i = 0; i < 6; i++) cmd(OP_POP, 16'h0);
      rd(IDX_X, 32'h000000A1);
      cmd(OP_LDIL, 16'h5A5A);
      rd(IDX_PC, 32'h00000111);
      rd(IDX_ACC, 32'h00005A5A);
      t = 16'($urandom);
      i_user_in <= t[2:0];
      i_timer_out <= t[4:3];
      wr(IDX_STATUS, 32'h0020);
      repeat (3) @(posedge i_clk);
      rd(IDX_STATUS, {20'h0, t[1:0], 10'h020});
      chk({29'h0, o_timer_clk_src}, {29'h0, t[2:0]});
      chk({30'h0, o_pin_out}, {30'h0, t[4:3]});
      wr(IDX_CTRL, 32'h3);
      @(posedge i_clk);
      #1 chk({30'h0, o_pin_out}, 32'h2);
      // both polarities, each pin direction, pending cleared after every look
      for (int pl = 0; pl < 2; pl++) begin
         wr(IDX_CTRL, 32'h1 | 32'(pl << 2));
         for (int lv = 1; lv >= 0; lv--) begin
            i_ext_irq <= 3'(lv);
            repeat (5) @(posedge i_clk);
            rd(IDX_IRQPND, 32'(lv == pl));
            wr(IDX_IRQPND, 32'hFF);
         end
      end
      wr(IDX_IRQPRI, 32'h00000480);
      wr(IDX_IRQEN, 32'h38);
      cmd(OP_JMP, 16'h0300);
      i_periph_irq <= 5'h07;
      @(posedge i_clk);
      i_periph_irq <= 5'h00;
      repeat (3) @(posedge i_clk);
      rd(IDX_IRQPND, 32'h38);
      p16 = 16'h0300;
      for (int i = 0; i < 3; i++) begin
         cmd(OP_SET_GLOBAL_IRQ_ENABLE_INSTR, 16'h0);
         p16 = p16 + 16'h1;
         rd(IDX_STACK, {13'h0, 3'(i + 1), p16});
         rd(IDX_PC, {16'h0, 8'(8'hFF - i), 8'h00});
         rd(IDX_CTRL, 32'h5);
         p16 = {8'(8'hFF - i), 8'h00};
      end
      rd(IDX_IRQPND, 32'h0);
      for (int k = 0; k < 4; k++) begin
         wr(IDX_CTRL, 32'(bk[k] << 8));
         t = 16'($urandom);
         wr(IDX_SLOT0 + 6'(sl[k]), {16'h0, t});
         rd(IDX_SLOT0 + 6'(sl[k]), {16'h0, t});
         n += int'(bk[k] > 4 || sl[k] >= bk[k] + 3);
         chk(32'(u_dcd_periph_model.wr_cnt), 32'(n));
      end
      rd(6'h3F, 32'h0);
      test_done();
   end
endmodule : tb_top
